// [core/byte_ops_pkg.sv]
// Purpose: Shared constants and types for the byte rotate/set execution core.
// Assumes: AXI4-Lite register access with 32-bit data and 8-bit byte addresses.
// Notes: Register offsets are byte addresses; every register is one aligned word.
package byte_ops_pkg;

  // Register map.
  localparam logic [7:0] OFS_INSN = 8'h00;
  localparam logic [7:0] OFS_WREG = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_BANK = 8'h0C;
  localparam logic [7:0] OFS_CFG = 8'h10;
  localparam logic [7:0] OFS_INDEX_BASE = 8'h14;
  localparam logic [7:0] OFS_FILE_PTR = 8'h18;
  localparam logic [7:0] OFS_FILE_DATA = 8'h1C;
  localparam logic [7:0] OFS_EXEC_STATE = 8'h20;

  // Field positions.
  localparam int STAT_C = 0;
  localparam int STAT_Z = 1;
  localparam int STAT_N = 2;
  localparam int CFG_EXT = 0;
  localparam int EXS_ILLEGAL = 0;
  localparam int EXS_BUSY = 1;

  // Reset values.
  localparam logic [15:0] INSN_RST = 16'h0000;
  localparam logic [7:0] WREG_RST = 8'h00;
  localparam logic [2:0] STATUS_RST = 3'h0;
  localparam logic [3:0] BANK_RST = 4'h0;
  localparam logic [11:0] INDEX_BASE_RST = 12'h000;
  localparam logic [11:0] FILE_PTR_RST = 12'h000;

  // Opcodes and addressing figures.
  localparam logic [5:0] OPC_RRC = 6'h0C;
  localparam logic [5:0] OPC_RRNC = 6'h10;
  localparam logic [6:0] OPC_SET = 7'h34;
  localparam logic [7:0] SET_VALUE = 8'hFF;
  localparam logic [7:0] ACC_LOW_TOP = 8'h5F;
  localparam logic [3:0] ACC_HIGH_BANK = 4'hF;
  localparam int FILE_DEPTH = 4096;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {OP_NONE, OP_RRC, OP_RRNC, OP_SET} op_t;
  typedef enum logic [2:0] {ST_IDLE, ST_DECODE, ST_READ, ST_PROCESS, ST_WRITE} phase_t;

  typedef struct packed {
    op_t op;
    logic dest;
    logic access;
    logic [7:0] faddr;
  } dec_t;

endpackage

// [core/rotate_set_core.sv]
// Purpose: Executes rotate-right-through-carry, rotate-right-no-carry and set-all-bits.
// Assumes: Software loads operands and an instruction word over AXI4-Lite.
// Notes: An instruction runs in four phases; bus writes other than flag clears are dropped unless idle.
`timescale 1ns/1ps
`default_nettype none

module rotate_set_core import byte_ops_pkg::*;
(
  input wire logic clk, // Core clock, 100 MHz.
  input wire logic rst_b, // Asynchronous reset, active low.
  input wire logic [7:0] awaddr, // Write address.
  input wire logic awvalid, // Write address valid.
  output logic awready, // Write address ready.
  input wire logic [31:0] wdata, // Write data.
  input wire logic [3:0] wstrb, // Write byte strobes.
  input wire logic wvalid, // Write data valid.
  output logic wready, // Write data ready.
  output logic [1:0] bresp, // Write response.
  output logic bvalid, // Write response valid.
  input wire logic bready, // Write response ready.
  input wire logic [7:0] araddr, // Read address.
  input wire logic arvalid, // Read address valid.
  output logic arready, // Read address ready.
  output logic [31:0] rdata, // Read data.
  output logic [1:0] rresp, // Read response.
  output logic rvalid, // Read data valid.
  input wire logic rready // Read data ready.
);

  function automatic logic [31:0] merge_strb(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] m;
    m = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        m[8*i +: 8] = new_v[8*i +: 8];
    end
    return m;
  endfunction

  function automatic dec_t decode_insn(input logic [15:0] w);
    dec_t d;
    d.op = OP_NONE;
    d.dest = w[9];
    d.access = w[8];
    d.faddr = w[7:0];
    if (w[15:10] == OPC_RRC)
      d.op = OP_RRC;
    else if (w[15:10] == OPC_RRNC)
      d.op = OP_RRNC;
    else if (w[15:9] == OPC_SET)
    begin
      d.op = OP_SET;
      d.dest = 1'b1;
    end
    return d;
  endfunction

  function automatic logic [11:0] resolve_addr(input dec_t d, input logic [3:0] bank,
                                               input logic ext, input logic [11:0] base);
    if (!d.access && ext && d.faddr <= ACC_LOW_TOP)
      return base + {4'h0, d.faddr};
    else if (!d.access)
      return (d.faddr <= ACC_LOW_TOP) ? {4'h0, d.faddr} : {ACC_HIGH_BANK, d.faddr};
    else
      return {bank, d.faddr};
  endfunction

  logic [7:0] file_mem [FILE_DEPTH];
  logic mem_we;
  logic [11:0] mem_wa;
  logic [7:0] mem_wd;

  logic aw_full_r, aw_full_nxt, w_full_r, w_full_nxt;
  logic [7:0] awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [15:0] insn_r, insn_nxt;
  logic [7:0] wreg_r, wreg_nxt;
  logic [2:0] status_r, status_nxt;
  logic [3:0] bank_r, bank_nxt;
  logic ext_r, ext_nxt;
  logic [11:0] base_r, base_nxt, file_ptr_r, file_ptr_nxt;
  logic illegal_r, illegal_nxt;
  phase_t phase_r, phase_nxt;
  dec_t dec_r, dec_nxt;
  logic [11:0] eff_r, eff_nxt;
  logic [7:0] operand_r, operand_nxt, result_r, result_nxt;
  logic [2:0] flags_r, flags_nxt;
  logic [31:0] wr_word, rd_word;
  logic idle;

  assign awready = !aw_full_r;
  assign wready = !w_full_r;
  assign arready = !rvalid_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign rvalid = rvalid_r;
  assign rresp = rresp_r;
  assign rdata = rdata_r;
  assign idle = (phase_r == ST_IDLE);
  assign wr_word = merge_strb(32'h0000_0000, wdata_r, wstrb_r);

  always_comb
  begin
    rd_word = 32'h0000_0000;
    unique case (araddr)
      OFS_INSN: rd_word = {16'h0000, insn_r};
      OFS_WREG: rd_word = {24'h00_0000, wreg_r};
      OFS_STATUS: rd_word = {29'h0000_0000, status_r};
      OFS_BANK: rd_word = {28'h000_0000, bank_r};
      OFS_CFG: rd_word = {31'h0000_0000, ext_r};
      OFS_INDEX_BASE: rd_word = {20'h0_0000, base_r};
      OFS_FILE_PTR: rd_word = {20'h0_0000, file_ptr_r};
      OFS_FILE_DATA: rd_word = {24'h00_0000, file_mem[file_ptr_r]};
      OFS_EXEC_STATE: rd_word = {30'h0000_0000, !idle, illegal_r};
      default: rd_word = 32'h0000_0000;
    endcase
  end

  always_comb
  begin
    {aw_full_nxt, w_full_nxt, awaddr_nxt} = {aw_full_r, w_full_r, awaddr_r};
    {wdata_nxt, wstrb_nxt, bvalid_nxt, bresp_nxt} = {wdata_r, wstrb_r, bvalid_r, bresp_r};
    {rvalid_nxt, rresp_nxt, rdata_nxt, insn_nxt} = {rvalid_r, rresp_r, rdata_r, insn_r};
    {wreg_nxt, status_nxt, bank_nxt, ext_nxt} = {wreg_r, status_r, bank_r, ext_r};
    {base_nxt, file_ptr_nxt, illegal_nxt} = {base_r, file_ptr_r, illegal_r};
    phase_nxt = phase_r;
    dec_nxt = dec_r;
    {eff_nxt, operand_nxt, result_nxt, flags_nxt} = {eff_r, operand_r, result_r, flags_r};
    mem_we = 1'b0;
    mem_wa = file_ptr_r;
    mem_wd = 8'h00;
    if (awvalid && !aw_full_r)
    begin
      aw_full_nxt = 1'b1;
      awaddr_nxt = awaddr;
    end
    if (wvalid && !w_full_r)
    begin
      w_full_nxt = 1'b1;
      wdata_nxt = wdata;
      wstrb_nxt = wstrb;
    end
    if (bvalid_r && bready)
      bvalid_nxt = 1'b0;
    // Writes that would race the datapath are dropped while busy, but still answered.
    if (aw_full_r && w_full_r && !bvalid_r)
    begin
      aw_full_nxt = 1'b0;
      w_full_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = RESP_OKAY;
      unique case (awaddr_r)
        OFS_INSN:
          if (idle)
          begin
            insn_nxt = 16'(merge_strb({16'h0000, insn_r}, wdata_r, wstrb_r));
            phase_nxt = ST_DECODE;
          end
        OFS_WREG: if (idle) wreg_nxt = wr_word[7:0];
        OFS_STATUS: if (idle) status_nxt = wr_word[2:0];
        OFS_BANK: if (idle) bank_nxt = wr_word[3:0];
        OFS_CFG: if (idle) ext_nxt = wr_word[CFG_EXT];
        OFS_INDEX_BASE: if (idle) base_nxt = wr_word[11:0];
        OFS_FILE_PTR: if (idle) file_ptr_nxt = wr_word[11:0];
        OFS_FILE_DATA:
          if (idle && wstrb_r[0])
          begin
            mem_we = 1'b1;
            mem_wd = wdata_r[7:0];
          end
        OFS_EXEC_STATE: if (wr_word[EXS_ILLEGAL]) illegal_nxt = 1'b0;
        default: bresp_nxt = RESP_SLVERR;
      endcase
    end
    if (rvalid_r && rready)
      rvalid_nxt = 1'b0;
    if (arvalid && !rvalid_r)
    begin
      rvalid_nxt = 1'b1;
      rdata_nxt = rd_word;
      rresp_nxt = (araddr[1:0] == 2'h0 && araddr <= OFS_EXEC_STATE) ? RESP_OKAY : RESP_SLVERR;
    end
    unique case (phase_r)
      ST_IDLE:
      begin
      end
      ST_DECODE:
      begin
        dec_nxt = decode_insn(insn_r);
        if (dec_nxt.op == OP_NONE)
        begin
          illegal_nxt = 1'b1;
          phase_nxt = ST_IDLE;
        end
        else
          phase_nxt = ST_READ;
      end
      ST_READ:
      begin
        eff_nxt = resolve_addr(dec_r, bank_r, ext_r, base_r);
        operand_nxt = file_mem[eff_nxt];
        phase_nxt = ST_PROCESS;
      end
      ST_PROCESS:
      begin
        flags_nxt = status_r;
        unique case (dec_r.op)
          OP_RRC:
          begin
            result_nxt = {status_r[STAT_C], operand_r[7:1]};
            flags_nxt[STAT_C] = operand_r[0];
          end
          OP_RRNC: result_nxt = {operand_r[0], operand_r[7:1]};
          default: result_nxt = SET_VALUE;
        endcase
        flags_nxt[STAT_N] = result_nxt[7];
        flags_nxt[STAT_Z] = (result_nxt == 8'h00);
        phase_nxt = ST_WRITE;
      end
      ST_WRITE:
      begin
        if (dec_r.op != OP_SET)
          status_nxt = flags_r;
        if (dec_r.dest)
        begin
          mem_we = 1'b1;
          mem_wa = eff_r;
          mem_wd = result_r;
        end
        else
          wreg_nxt = result_r;
        phase_nxt = ST_IDLE;
      end
    endcase
  end

  // The file memory has no reset; software must initialise locations it relies on.
  always_ff @(posedge clk)
  begin
    if (mem_we)
      file_mem[mem_wa] <= mem_wd;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      rvalid_r <= 1'b0;
      rresp_r <= RESP_OKAY;
      rdata_r <= 32'h0000_0000;
      insn_r <= INSN_RST;
      wreg_r <= WREG_RST;
      status_r <= STATUS_RST;
      bank_r <= BANK_RST;
      ext_r <= 1'b0;
      base_r <= INDEX_BASE_RST;
      file_ptr_r <= FILE_PTR_RST;
      illegal_r <= 1'b0;
      phase_r <= ST_IDLE;
      dec_r <= '0;
      eff_r <= 12'h000;
      operand_r <= 8'h00;
      result_r <= 8'h00;
      flags_r <= STATUS_RST;
    end
    else
    begin
      {aw_full_r, w_full_r, awaddr_r} <= {aw_full_nxt, w_full_nxt, awaddr_nxt};
      {wdata_r, wstrb_r, bvalid_r, bresp_r} <= {wdata_nxt, wstrb_nxt, bvalid_nxt, bresp_nxt};
      {rvalid_r, rresp_r, rdata_r, insn_r} <= {rvalid_nxt, rresp_nxt, rdata_nxt, insn_nxt};
      {wreg_r, status_r, bank_r, ext_r} <= {wreg_nxt, status_nxt, bank_nxt, ext_nxt};
      {base_r, file_ptr_r, illegal_r} <= {base_nxt, file_ptr_nxt, illegal_nxt};
      phase_r <= phase_nxt;
      dec_r <= dec_nxt;
      {eff_r, operand_r, result_r, flags_r} <= {eff_nxt, operand_nxt, result_nxt, flags_nxt};
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  a_decode_rrc: assert property (phase_r == ST_DECODE && insn_r[15:10] == 6'h0C
    |=> dec_r.op == OP_RRC && phase_r == ST_READ) else $error("rrc not decoded");
  a_phase_walk: assert property (phase_r == ST_DECODE && dec_nxt.op != OP_NONE
    |=> phase_r == ST_READ ##1 phase_r == ST_PROCESS ##1 phase_r == ST_WRITE ##1 idle)
    else $error("phase sequence broken");
  a_rrc_result: assert property (phase_r == ST_PROCESS && dec_r.op == OP_RRC
    |=> result_r == {$past(status_r[STAT_C]), $past(operand_r[7:1])}
    ##1 status_r[STAT_C] == $past(operand_r[0], 2)) else $error("rrc result or carry wrong");
  a_rrnc_keep_c: assert property (phase_r == ST_PROCESS && dec_r.op == OP_RRNC
    |=> result_r == {$past(operand_r[0]), $past(operand_r[7:1])}
    ##1 $stable(status_r[STAT_C])) else $error("rrnc result or carry wrong");
  a_rot_dest_w: assert property (phase_r == ST_WRITE && dec_r.op != OP_SET && !dec_r.dest
    |=> wreg_r == $past(result_r)) else $error("w not written");
  a_rot_dest_f: assert property (phase_r == ST_WRITE && dec_r.dest
    |=> file_mem[$past(eff_r)] == $past(result_r) && $stable(wreg_r))
    else $error("file register not written");
  a_access_bank: assert property (phase_r == ST_READ && !dec_r.access
    && !(ext_r && dec_r.faddr <= 8'h5F) |=> eff_r[7:0] == $past(dec_r.faddr)
    && eff_r[11:8] == (($past(dec_r.faddr) <= 8'h5F) ? 4'h0 : 4'hF))
    else $error("access bank address wrong");
  a_indexed_mode: assert property (phase_r == ST_READ && !dec_r.access && ext_r
    && dec_r.faddr <= 8'h5F |=> eff_r == $past(base_r) + {4'h0, $past(dec_r.faddr)})
    else $error("indexed address wrong");
  a_set_no_flags: assert property (phase_r == ST_WRITE && dec_r.op == OP_SET
    |=> $stable(status_r) && file_mem[$past(eff_r)] == 8'hFF) else $error("set wrong");

  c_rrc_to_f: cover property (phase_r == ST_WRITE && dec_r.op == OP_RRC && dec_r.dest);
  c_rrnc_to_w: cover property (phase_r == ST_WRITE && dec_r.op == OP_RRNC && !dec_r.dest);
  c_set_banked: cover property (phase_r == ST_WRITE && dec_r.op == OP_SET && dec_r.access);
  c_indexed: cover property (phase_r == ST_READ && !dec_r.access && ext_r);

endmodule

`default_nettype wire

// [verification/axil_master.sv]
// Purpose: AXI4-Lite master that stands in for software driving the core.
// Assumes: One clock; one write and one read at most under way at a time.
// Notes: Waits have no limit here, because the bench timeout ends any hang.
`timescale 1ns/1ps
`default_nettype none
module axil_master
(
  input wire logic clk, // Core clock.
  output logic [7:0] awaddr, // Write address.
  output logic awvalid, // Write address valid.
  input wire logic awready, // Write address ready.
  output logic [31:0] wdata, // Write data.
  output logic [3:0] wstrb, // Write byte strobes.
  output logic wvalid, // Write data valid.
  input wire logic wready, // Write data ready.
  input wire logic [1:0] bresp, // Write response.
  input wire logic bvalid, // Write response valid.
  output logic bready, // Write response ready.
  output logic [7:0] araddr, // Read address.
  output logic arvalid, // Read address valid.
  input wire logic arready, // Read address ready.
  input wire logic [31:0] rdata, // Read data.
  input wire logic [1:0] rresp, // Read response.
  input wire logic rvalid, // Read data valid.
  output logic rready // Read data ready.
);
  initial
  begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end

  // Address and data go out together; each drops at the edge that takes it.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hF;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arready)
        arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
endmodule
`default_nettype wire

// [verification/tb.sv]
// Purpose: Self-checking bench for the rotate and set execution core.
// Assumes: Operands are placed in file memory through the pointer and data window.
// Notes: Busy is polled twice per instruction, which bounds the run to between three and five phases.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("Error at %0t: value %h, expected %h", $time, (g), (e)); end end
module tb import byte_ops_pkg::*;
;
  logic clk, rst_b, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  int mismatches = 0;
  int n_checks = 0;
  int cycles = 0;

  rotate_set_core dut (.clk(clk), .rst_b(rst_b), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
  axil_master bus (.clk(clk), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic test_done;
    if (mismatches == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // The run is several hundred cycles, so this ceiling only trips on a hang.
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      test_done();
    end
  end

  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    bus.wr(a, d, r);
    `CHK(r, RESP_OKAY)
  endtask

  task automatic poke(input logic [11:0] loc, input logic [7:0] v);
    wreg(OFS_FILE_PTR, {20'h0_0000, loc});
    wreg(OFS_FILE_DATA, {24'h00_0000, v});
  endtask

  task automatic peek(input logic [11:0] loc, output logic [7:0] v);
    logic [1:0] r;
    logic [31:0] d;
    wreg(OFS_FILE_PTR, {20'h0_0000, loc});
    bus.rd(OFS_FILE_DATA, d, r);
    v = d[7:0];
  endtask

  task automatic run(input logic [15:0] insn);
    logic [1:0] r;
    logic [31:0] d;
    wreg(OFS_INSN, {16'h0000, insn});
    bus.rd(OFS_EXEC_STATE, d, r);
    `CHK(d[EXS_BUSY], 1'b1)
    bus.rd(OFS_EXEC_STATE, d, r);
    `CHK(d[EXS_BUSY], 1'b0)
  endtask

  // Marker 5Ah in W shows whether the result went to W or to the file register.
  task automatic op_case(input logic [15:0] insn, input logic [11:0] loc, input logic [7:0] init,
                         input logic [2:0] st_in, input logic [7:0] res, input logic [2:0] st);
    logic [1:0] r;
    logic [31:0] d;
    logic [7:0] v;
    logic to_file;
    to_file = insn[9] || (insn[15:9] == OPC_SET);
    poke(loc, init);
    wreg(OFS_STATUS, {29'h0000_0000, st_in});
    wreg(OFS_WREG, 32'h0000_005A);
    run(insn);
    bus.rd(OFS_WREG, d, r);
    `CHK(d[7:0], to_file ? 8'h5A : res)
    peek(loc, v);
    `CHK(v, to_file ? res : init)
    bus.rd(OFS_STATUS, d, r);
    `CHK(d[2:0], st)
  endtask

  task automatic t_reset;
    logic [7:0] ofs [8] = '{OFS_INSN, OFS_WREG, OFS_STATUS, OFS_BANK, OFS_CFG,
                            OFS_INDEX_BASE, OFS_FILE_PTR, OFS_EXEC_STATE};
    logic [1:0] r;
    logic [31:0] d;
    foreach (ofs[i])
    begin
      bus.rd(ofs[i], d, r);
      `CHK({r, d}, {RESP_OKAY, 32'h0000_0000})
    end
    bus.rd(8'h24, d, r);
    `CHK({r, d}, {RESP_SLVERR, 32'h0000_0000})
    bus.wr(8'h24, 32'h0000_0000, r);
    `CHK(r, RESP_SLVERR)
  endtask

  task automatic t_rrc;
    op_case({OPC_RRC, 1'b0, 1'b0, 8'h20}, 12'h020, 8'hE6, 3'h0, 8'h73, 3'h0);
    op_case({OPC_RRC, 1'b1, 1'b0, 8'h21}, 12'h021, 8'h01, 3'h1, 8'h80, 3'h5);
    op_case({OPC_RRC, 1'b1, 1'b0, 8'h22}, 12'h022, 8'h01, 3'h0, 8'h00, 3'h3);
  endtask

  task automatic t_rrnc;
    op_case({OPC_RRNC, 1'b1, 1'b0, 8'h30}, 12'h030, 8'hD7, 3'h0, 8'hEB, 3'h4);
    op_case({OPC_RRNC, 1'b0, 1'b0, 8'h31}, 12'h031, 8'h02, 3'h7, 8'h01, 3'h1);
  endtask

  task automatic t_set;
    wreg(OFS_BANK, 32'h0000_0003);
    op_case({OPC_SET, 1'b1, 8'h45}, 12'h345, 8'h12, 3'h5, SET_VALUE, 3'h5);
    op_case({OPC_SET, 1'b0, 8'h90}, 12'hF90, 8'h00, 3'h2, SET_VALUE, 3'h2);
  endtask

  task automatic t_bank;
    logic [7:0] v;
    wreg(OFS_BANK, 32'h0000_0002);
    poke(12'h010, 8'h33);
    op_case({OPC_RRNC, 1'b1, 1'b1, 8'h10}, 12'h210, 8'h04, 3'h0, 8'h02, 3'h0);
    peek(12'h010, v);
    `CHK(v, 8'h33)
    op_case({OPC_RRC, 1'b1, 1'b0, 8'h80}, 12'hF80, 8'h10, 3'h0, 8'h08, 3'h0);
  endtask

  task automatic t_ext;
    wreg(OFS_CFG, 32'h0000_0001);
    wreg(OFS_INDEX_BASE, 32'h0000_0400);
    op_case({OPC_RRNC, 1'b1, 1'b0, 8'h5F}, 12'h45F, 8'h06, 3'h0, 8'h03, 3'h0);
    op_case({OPC_RRNC, 1'b1, 1'b0, 8'h60}, 12'hF60, 8'h06, 3'h0, 8'h03, 3'h0);
    op_case({OPC_RRNC, 1'b1, 1'b1, 8'h05}, 12'h205, 8'h06, 3'h0, 8'h03, 3'h0);
    op_case({OPC_SET, 1'b0, 8'h07}, 12'h407, 8'h00, 3'h0, SET_VALUE, 3'h0);
    wreg(OFS_CFG, 32'h0000_0000);
  endtask

  // A word one bit off the through-carry opcode must not execute.
  task automatic t_illegal;
    logic [1:0] r;
    logic [31:0] d;
    logic [7:0] v;
    poke(12'h040, 8'h81);
    wreg(OFS_INSN, {16'h0000, 6'h0D, 1'b1, 1'b0, 8'h40});
    bus.rd(OFS_EXEC_STATE, d, r);
    `CHK(d[1:0], 2'h1)
    peek(12'h040, v);
    `CHK(v, 8'h81)
    wreg(OFS_EXEC_STATE, 32'h0000_0001);
    bus.rd(OFS_EXEC_STATE, d, r);
    `CHK(d[1:0], 2'h0)
  endtask

  initial
  begin
    rst_b = 1'b0;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_rrc();
    t_rrnc();
    t_set();
    t_bank();
    t_ext();
    t_illegal();
    test_done();
  end
endmodule
`default_nettype wire
